// file: core/tws_map.svh
// Register offsets, field positions, reset values and status codes
`ifndef TWS_MAP_SVH
`define TWS_MAP_SVH

`define TWS_OFF_RATE     8'hb8
`define TWS_OFF_STATUS   8'hb9
`define TWS_OFF_OWN      8'hba
`define TWS_OFF_DATA     8'hbb
`define TWS_OFF_CTRL     8'hbc
`define TWS_OFF_MASK     8'hbd

`define TWS_RST_RATE     8'h00
`define TWS_RST_PRESCALE 2'h0
`define TWS_RST_OWN      8'hfe
`define TWS_RST_DATA     8'hff
`define TWS_RST_MASK     7'h00

`define TWS_CTL_DONE     7
`define TWS_CTL_ACK      6
`define TWS_CTL_STA      5
`define TWS_CTL_STO      4
`define TWS_CTL_WCOL     3
`define TWS_CTL_EN       2
`define TWS_CTL_IE       0
`define TWS_OWN_GCE      0

`define TWS_RATE_BASE    15'h0008
`define TWS_BIT_ACK      4'h8
`define TWS_BIT_PRE      4'hf

// Status codes, upper five bits of the status register
`define TWS_ST_START     5'h01
`define TWS_ST_RSTART    5'h02
`define TWS_ST_MT_SLA_A  5'h03
`define TWS_ST_MT_SLA_N  5'h04
`define TWS_ST_MT_DAT_A  5'h05
`define TWS_ST_MT_DAT_N  5'h06
`define TWS_ST_LOST      5'h07
`define TWS_ST_MR_SLA_A  5'h08
`define TWS_ST_MR_SLA_N  5'h09
`define TWS_ST_MR_DAT_A  5'h0a
`define TWS_ST_MR_DAT_N  5'h0b
`define TWS_ST_SR_OWN    5'h0c
`define TWS_ST_SR_GC     5'h0e
`define TWS_ST_SR_DAT_A  5'h10
`define TWS_ST_SR_DAT_N  5'h11
`define TWS_ST_GC_DAT_A  5'h12
`define TWS_ST_GC_DAT_N  5'h13
`define TWS_ST_SR_STOP   5'h14
`define TWS_ST_ST_OWN    5'h15
`define TWS_ST_ST_DAT_A  5'h17
`define TWS_ST_ST_DAT_N  5'h18
`define TWS_ST_NONE      5'h1f

`endif

// file: core/tws_pkg.sv
// Types shared by the two-wire unit
package tws_pkg;
	typedef enum logic [2:0] {
		TWS_OFF    = 3'b000,
		TWS_IDLE   = 3'b001,
		TWS_XFER   = 3'b010,
		TWS_HOLD   = 3'b011,
		TWS_MSTART = 3'b100,
		TWS_MSTOP  = 3'b101
	} tws_state_t;
endpackage

// file: core/tws_pin_filter.sv
// Pin synchroniser with a one-sample spike filter
`timescale 1ns/10ps
module tws_pin_filter
(
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic rst,
	// Pin and control
	input  wire logic pin,
	input  wire logic filter_en,
	// Clean level
	output logic      level
);
	logic meta_reg;
	logic sync_reg;
	logic last_reg;

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			meta_reg <= 1'b1;
			sync_reg <= 1'b1;
			last_reg <= 1'b1;
			level    <= 1'b1;
		end
		else
		begin
			meta_reg <= pin;
			sync_reg <= meta_reg;
			last_reg <= sync_reg;
			// With filter_en set, a single odd sample never reaches the bus logic
			if (!filter_en || sync_reg == last_reg)
				level <= sync_reg;
		end
	end
endmodule // tws_pin_filter

// file: core/tws_rate.sv
// Half-period tick divider for the master SCL
`include "tws_map.svh"
`timescale 1ns/10ps
module tws_rate
(
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst,
	// Control
	input  wire logic       run,
	input  wire logic [7:0] divisor,
	input  wire logic [1:0] prescale_sel,
	// One-cycle pulse each SCL half period
	output logic            tick
);
	logic [14:0] scaled;
	logic [14:0] period;
	logic [14:0] count_reg;

	// Half period is base plus divisor times 1, 4, 16 or 64
	assign scaled = {7'h00, divisor} << {prescale_sel, 1'b0};
	assign period = scaled + `TWS_RATE_BASE;

	always_ff @(posedge sys_clk)
	begin
		if (rst || !run)
		begin
			count_reg <= 15'h0000;
			tick      <= 1'b0;
		end
		else if (count_reg >= period - 15'h0001)
		begin
			count_reg <= 15'h0000;
			tick      <= 1'b1;
		end
		else
		begin
			count_reg <= count_reg + 15'h0001;
			tick      <= 1'b0;
		end
	end
endmodule // tws_rate

// file: core/tws_ctrl.sv
// Two-wire serial bus controller: registers and byte engine
`include "tws_map.svh"
`timescale 1ns/10ps
module tws_ctrl
(
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst,
	// Register port
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	// Processor interrupt
	input  wire logic       global_irq_enable,
	output logic            irq,
	// Two-wire bus pins
	input  wire logic       scl_in,
	output logic            scl_out,
	output logic            scl_oe,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe
);
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction

	tws_pkg::tws_state_t state_reg;
	logic [7:0] rate_reg;
	logic [1:0] prescale_reg;
	logic [7:0] own_addr_reg;
	logic [6:0] mask_reg;
	logic [7:0] shift_reg;
	logic [4:0] status_reg;
	logic [1:0] phase_reg;
	logic [3:0] bit_cnt_reg;
	logic       job_done_reg;
	logic       ack_en_reg;
	logic       start_req_reg;
	logic       stop_req_reg;
	logic       wcol_reg;
	logic       enable_reg;
	logic       irq_en_reg;
	logic       master_reg;
	logic       xmit_reg;
	logic       addr_phase_reg;
	logic       addressed_reg;
	logic       gc_reg;
	logic       lost_reg;
	logic       nack_reg;
	logic       ack_rx_reg;
	logic       after_start_reg;
	logic       bus_busy_reg;
	logic       scl_prev_reg;
	logic       sda_prev_reg;
	logic       scl_f;
	logic       sda_f;
	logic       tick;
	logic       wr_data;
	logic       wr_ctrl;
	logic       go;
	logic       start_det;
	logic       stop_det;
	logic       in_xfer;
	logic       m_high_done;
	logic       lose;
	logic       rise;
	logic       fall;
	logic       ack_bit;
	logic       own_hit;
	logic       gc_hit;
	logic       ack_send;
	logic       scl_want;
	logic       sda_want;

	tws_pin_filter u_scl_filter
	(
		.sys_clk   (sys_clk),
		.rst       (rst),
		.pin       (scl_in),
		.filter_en (enable_reg),
		.level     (scl_f)
	);

	tws_pin_filter u_sda_filter
	(
		.sys_clk   (sys_clk),
		.rst       (rst),
		.pin       (sda_in),
		.filter_en (enable_reg),
		.level     (sda_f)
	);

	tws_rate u_rate
	(
		.sys_clk      (sys_clk),
		.rst          (rst),
		.run          (enable_reg),
		.divisor      (rate_reg),
		.prescale_sel (prescale_reg),
		.tick         (tick)
	);

	assign wr_data = reg_wr && hit(reg_addr, `TWS_OFF_DATA);
	assign wr_ctrl = reg_wr && hit(reg_addr, `TWS_OFF_CTRL);
	assign go      = wr_ctrl && reg_wdata[`TWS_CTL_DONE];

	assign start_det = scl_f && scl_prev_reg && sda_prev_reg && !sda_f;
	assign stop_det  = scl_f && scl_prev_reg && !sda_prev_reg && sda_f;
	assign in_xfer   = state_reg == tws_pkg::TWS_XFER;

	// Master clocks the bit itself; a slave follows the bus edges
	assign m_high_done = in_xfer && master_reg && phase_reg[0] && tick
		&& scl_f;
	assign lose = m_high_done && xmit_reg && !bit_cnt_reg[3]
		&& shift_reg[7] && !sda_f;
	assign rise = (in_xfer && !master_reg && scl_f && !scl_prev_reg)
		|| m_high_done;
	assign fall = (in_xfer && !master_reg && !scl_f && scl_prev_reg)
		|| (m_high_done && !lose);
	assign ack_bit = m_high_done ? sda_f : ack_rx_reg;

	// Masked compare against the own address; master modes never match
	assign own_hit = !master_reg && (shift_reg[7:1] != 7'h00)
		&& (((shift_reg[7:1] ^ own_addr_reg[7:1]) & ~mask_reg) == 7'h00);
	assign gc_hit  = !master_reg && (shift_reg[7:1] == 7'h00)
		&& own_addr_reg[`TWS_OWN_GCE];

	always_comb
	begin
		if (addr_phase_reg && !master_reg)
			ack_send = ack_en_reg && (own_hit || gc_hit);
		else
			ack_send = ack_en_reg && (master_reg || addressed_reg);
	end

	// Pin drive wishes; a one means pull the line low
	always_comb
	begin
		scl_want = 1'b0;
		sda_want = 1'b0;
		unique case (state_reg)
			tws_pkg::TWS_XFER:
			begin
				scl_want = master_reg && !phase_reg[0];
				if (bit_cnt_reg < `TWS_BIT_ACK)
					sda_want = xmit_reg && !shift_reg[7];
				else if (bit_cnt_reg == `TWS_BIT_ACK)
					sda_want = !xmit_reg && ack_send;
			end
			tws_pkg::TWS_HOLD:
			begin
				scl_want = master_reg || addressed_reg;
				sda_want = master_reg && after_start_reg;
			end
			tws_pkg::TWS_MSTART:
			begin
				scl_want = phase_reg == 2'h0;
				sda_want = phase_reg == 2'h2;
			end
			tws_pkg::TWS_MSTOP:
			begin
				scl_want = phase_reg == 2'h0;
				sda_want = phase_reg != 2'h2;
			end
			default:
			begin
				scl_want = 1'b0;
				sda_want = 1'b0;
			end
		endcase
	end

	// Software-owned settings
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			rate_reg      <= `TWS_RST_RATE;
			prescale_reg  <= `TWS_RST_PRESCALE;
			own_addr_reg  <= `TWS_RST_OWN;
			mask_reg      <= `TWS_RST_MASK;
			ack_en_reg    <= 1'b0;
			start_req_reg <= 1'b0;
			enable_reg    <= 1'b0;
			irq_en_reg    <= 1'b0;
		end
		else if (reg_wr)
		begin
			if (hit(reg_addr, `TWS_OFF_RATE))
				rate_reg <= reg_wdata;
			if (hit(reg_addr, `TWS_OFF_STATUS))
				prescale_reg <= reg_wdata[1:0];
			if (hit(reg_addr, `TWS_OFF_OWN))
				own_addr_reg <= reg_wdata;
			if (hit(reg_addr, `TWS_OFF_MASK))
				mask_reg <= reg_wdata[7:1];
			if (wr_ctrl)
			begin
				ack_en_reg    <= reg_wdata[`TWS_CTL_ACK];
				start_req_reg <= reg_wdata[`TWS_CTL_STA];
				enable_reg    <= reg_wdata[`TWS_CTL_EN];
				irq_en_reg    <= reg_wdata[`TWS_CTL_IE];
			end
		end
	end

	// Write collision: data writes outside job-done are refused
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			wcol_reg <= 1'b0;
		else if (wr_data)
			wcol_reg <= !job_done_reg;
	end

	// Bus line history and busy tracking
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
			bus_busy_reg <= 1'b0;
		end
		else
		begin
			scl_prev_reg <= scl_f;
			sda_prev_reg <= sda_f;
			if (!enable_reg || stop_det)
				bus_busy_reg <= 1'b0;
			else if (start_det)
				bus_busy_reg <= 1'b1;
		end
	end

	// Byte engine
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			state_reg       <= tws_pkg::TWS_OFF;
			shift_reg       <= `TWS_RST_DATA;
			status_reg      <= `TWS_ST_NONE;
			phase_reg       <= 2'h0;
			bit_cnt_reg     <= 4'h0;
			job_done_reg    <= 1'b0;
			stop_req_reg    <= 1'b0;
			master_reg      <= 1'b0;
			xmit_reg        <= 1'b0;
			addr_phase_reg  <= 1'b0;
			addressed_reg   <= 1'b0;
			gc_reg          <= 1'b0;
			lost_reg        <= 1'b0;
			nack_reg        <= 1'b0;
			ack_rx_reg      <= 1'b1;
			after_start_reg <= 1'b0;
		end
		else
		begin
			// Any set below is written later and so wins over a clear
			if (go)
			begin
				job_done_reg <= 1'b0;
				status_reg   <= `TWS_ST_NONE;
			end
			if (wr_ctrl)
				stop_req_reg <= reg_wdata[`TWS_CTL_STO];
			if (wr_data && job_done_reg)
				shift_reg <= reg_wdata;
			if (!enable_reg)
			begin
				state_reg     <= tws_pkg::TWS_OFF;
				master_reg    <= 1'b0;
				addressed_reg <= 1'b0;
				lost_reg      <= 1'b0;
			end
			else
			begin
				unique case (state_reg)
					tws_pkg::TWS_OFF:
						state_reg <= tws_pkg::TWS_IDLE;
					tws_pkg::TWS_IDLE:
					begin
						if (start_det)
						begin
							state_reg      <= tws_pkg::TWS_XFER;
							bit_cnt_reg    <= `TWS_BIT_PRE;
							addr_phase_reg <= 1'b1;
							xmit_reg       <= 1'b0;
						end
						else if (start_req_reg)
						begin
							state_reg <= tws_pkg::TWS_MSTART;
							phase_reg <= 2'h1;
						end
					end
					tws_pkg::TWS_XFER:
					begin
						if (start_det && !master_reg)
						begin
							bit_cnt_reg    <= `TWS_BIT_PRE;
							addr_phase_reg <= 1'b1;
							addressed_reg  <= 1'b0;
							xmit_reg       <= 1'b0;
						end
						else if (stop_det && !master_reg)
						begin
							addressed_reg <= 1'b0;
							lost_reg      <= 1'b0;
							if (addressed_reg && !xmit_reg)
							begin
								status_reg   <= `TWS_ST_SR_STOP;
								job_done_reg <= 1'b1;
								state_reg    <= tws_pkg::TWS_HOLD;
							end
							else
								state_reg <= tws_pkg::TWS_IDLE;
						end
						else
						begin
							if (master_reg && !phase_reg[0] && tick)
								phase_reg <= 2'h1;
							if (m_high_done)
								phase_reg <= 2'h0;
							if (lose)
							begin
								master_reg <= 1'b0;
								xmit_reg   <= 1'b0;
								lost_reg   <= 1'b1;
							end
							// Bus bits enter even while sending
							if (rise && !bit_cnt_reg[3])
								shift_reg <= {shift_reg[6:0], sda_f};
							else if (rise)
								ack_rx_reg <= sda_f;
							if (fall && bit_cnt_reg == `TWS_BIT_ACK)
							begin
								bit_cnt_reg  <= 4'h0;
								job_done_reg <= 1'b1;
								state_reg    <= tws_pkg::TWS_HOLD;
								if (addr_phase_reg && !master_reg)
								begin
									addr_phase_reg <= 1'b0;
									lost_reg       <= 1'b0;
									if (ack_send)
									begin
										addressed_reg <= 1'b1;
										gc_reg        <= !own_hit;
										xmit_reg      <= shift_reg[0];
										nack_reg      <= 1'b0;
										if (shift_reg[0])
											status_reg <= `TWS_ST_ST_OWN;
										else if (own_hit)
											status_reg <= `TWS_ST_SR_OWN;
										else
											status_reg <= `TWS_ST_SR_GC;
									end
									else if (lost_reg)
										status_reg <= `TWS_ST_LOST;
									else
									begin
										job_done_reg <= 1'b0;
										state_reg    <= tws_pkg::TWS_IDLE;
									end
								end
								else if (master_reg && addr_phase_reg)
								begin
									addr_phase_reg <= 1'b0;
									xmit_reg       <= !shift_reg[0];
									if (shift_reg[0])
										status_reg <= !ack_bit ?
											`TWS_ST_MR_SLA_A : `TWS_ST_MR_SLA_N;
									else
										status_reg <= !ack_bit ?
											`TWS_ST_MT_SLA_A : `TWS_ST_MT_SLA_N;
								end
								else if (master_reg && xmit_reg)
									status_reg <= !ack_bit ?
										`TWS_ST_MT_DAT_A : `TWS_ST_MT_DAT_N;
								else if (master_reg)
									status_reg <= ack_send ?
										`TWS_ST_MR_DAT_A : `TWS_ST_MR_DAT_N;
								else if (addressed_reg && xmit_reg)
								begin
									nack_reg   <= ack_bit;
									status_reg <= !ack_bit ?
										`TWS_ST_ST_DAT_A : `TWS_ST_ST_DAT_N;
								end
								else if (addressed_reg && gc_reg)
								begin
									nack_reg   <= !ack_send;
									status_reg <= ack_send ?
										`TWS_ST_GC_DAT_A : `TWS_ST_GC_DAT_N;
								end
								else if (addressed_reg)
								begin
									nack_reg   <= !ack_send;
									status_reg <= ack_send ?
										`TWS_ST_SR_DAT_A : `TWS_ST_SR_DAT_N;
								end
								else
								begin
									lost_reg   <= 1'b0;
									status_reg <= `TWS_ST_LOST;
								end
							end
							else if (fall && bit_cnt_reg == `TWS_BIT_PRE)
								bit_cnt_reg <= 4'h0;
							else if (fall)
								bit_cnt_reg <= bit_cnt_reg + 4'h1;
						end
					end
					tws_pkg::TWS_HOLD:
					begin
						// Clearing job-done releases the stretched clock
						if (go)
						begin
							after_start_reg <= 1'b0;
							bit_cnt_reg     <= 4'h0;
							phase_reg       <= 2'h0;
							if (reg_wdata[`TWS_CTL_STO] && master_reg)
								state_reg <= tws_pkg::TWS_MSTOP;
							else if (reg_wdata[`TWS_CTL_STO])
							begin
								addressed_reg <= 1'b0;
								stop_req_reg  <= 1'b0;
								state_reg     <= tws_pkg::TWS_IDLE;
							end
							else if (reg_wdata[`TWS_CTL_STA])
							begin
								state_reg <= tws_pkg::TWS_MSTART;
								phase_reg <= master_reg ? 2'h0 : 2'h1;
							end
							else if (master_reg || (addressed_reg && !nack_reg))
							begin
								state_reg      <= tws_pkg::TWS_XFER;
								addr_phase_reg <= after_start_reg;
								xmit_reg       <= xmit_reg || after_start_reg;
							end
							else
							begin
								addressed_reg <= 1'b0;
								state_reg     <= tws_pkg::TWS_IDLE;
							end
						end
					end
					tws_pkg::TWS_MSTART:
					begin
						if (start_det && !master_reg && phase_reg != 2'h2)
						begin
							state_reg      <= tws_pkg::TWS_XFER;
							bit_cnt_reg    <= `TWS_BIT_PRE;
							addr_phase_reg <= 1'b1;
							xmit_reg       <= 1'b0;
						end
						else if (tick)
						begin
							if (phase_reg == 2'h0)
								phase_reg <= 2'h1;
							else if (phase_reg == 2'h1)
							begin
								// Wait for a STOP unless the bus is already ours
								if (scl_f && sda_f && (master_reg || !bus_busy_reg))
									phase_reg <= 2'h2;
							end
							else
							begin
								status_reg      <= master_reg ?
									`TWS_ST_RSTART : `TWS_ST_START;
								master_reg      <= 1'b1;
								after_start_reg <= 1'b1;
								addressed_reg   <= 1'b0;
								lost_reg        <= 1'b0;
								job_done_reg    <= 1'b1;
								phase_reg       <= 2'h0;
								state_reg       <= tws_pkg::TWS_HOLD;
							end
						end
					end
					tws_pkg::TWS_MSTOP:
					begin
						if (tick)
						begin
							if (phase_reg == 2'h0)
								phase_reg <= 2'h1;
							else if (phase_reg == 2'h1 && scl_f)
								phase_reg <= 2'h2;
							else if (phase_reg == 2'h2)
							begin
								stop_req_reg <= 1'b0;
								master_reg   <= 1'b0;
								xmit_reg     <= 1'b0;
								phase_reg    <= 2'h0;
								state_reg    <= tws_pkg::TWS_IDLE;
							end
						end
					end
					default:
						state_reg <= tws_pkg::TWS_OFF;
				endcase
			end
		end
	end

	// Registered pins and interrupt
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			scl_out <= 1'b0;
			sda_out <= 1'b0;
			scl_oe  <= 1'b0;
			sda_oe  <= 1'b0;
			irq     <= 1'b0;
		end
		else
		begin
			scl_out <= 1'b0;
			sda_out <= 1'b0;
			scl_oe  <= enable_reg && scl_want;
			sda_oe  <= enable_reg && sda_want;
			irq     <= job_done_reg && irq_en_reg && global_irq_enable;
		end
	end

	// Read data stand for one cycle after the strobe
	always_ff @(posedge sys_clk)
	begin
		if (rst || !reg_rd)
			reg_rdata <= 8'h00;
		else if (hit(reg_addr, `TWS_OFF_RATE))
			reg_rdata <= rate_reg;
		else if (hit(reg_addr, `TWS_OFF_STATUS))
			reg_rdata <= {status_reg, 1'b0, prescale_reg};
		else if (hit(reg_addr, `TWS_OFF_OWN))
			reg_rdata <= own_addr_reg;
		else if (hit(reg_addr, `TWS_OFF_DATA))
			reg_rdata <= shift_reg;
		else if (hit(reg_addr, `TWS_OFF_CTRL))
			reg_rdata <= {job_done_reg, ack_en_reg, start_req_reg,
				stop_req_reg, wcol_reg, enable_reg, 1'b0, irq_en_reg};
		else if (hit(reg_addr, `TWS_OFF_MASK))
			reg_rdata <= {mask_reg, 1'b0};
		else
			reg_rdata <= 8'h00;
	end
endmodule // tws_ctrl

// file: verif/tws_ctrl_assertions.sv
// Port-level checks for the two-wire controller
`include "tws_map.svh"
`timescale 1ns/10ps
module tws_ctrl_assertions
(
	// Clock and reset
	input wire logic       sys_clk,
	input wire logic       rst,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	// Interrupt and pins
	input wire logic       global_irq_enable,
	input wire logic       irq,
	input wire logic       scl_out,
	input wire logic       scl_oe,
	input wire logic       sda_out,
	input wire logic       sda_oe
);
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	chk_rdata_idle: assert property
		(!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data not idle");
	chk_ctrl_bit1: assert property
		($past(reg_rd) && $past(reg_addr) == `TWS_OFF_CTRL |-> !reg_rdata[1])
		else $error("control bit 1 not zero");
	chk_mask_bit0: assert property
		($past(reg_rd) && $past(reg_addr) == `TWS_OFF_MASK |-> !reg_rdata[0])
		else $error("mask bit 0 not zero");
	chk_irq_gated: assert property
		(!$past(global_irq_enable) |-> !irq)
		else $error("irq without global enable");
	chk_irq_hold: assert property
		(irq && global_irq_enable && !reg_wr && !$past(reg_wr) |=> irq)
		else $error("irq dropped without a write");
	// Gated on a quiet register port so the rise can only come from job done
	chk_scl_stretch: assert property
		($rose(irq) && $past(global_irq_enable) && $past(global_irq_enable, 2)
		&& !$past(reg_wr) && !$past(reg_wr, 2) |-> ##[0:3] scl_oe)
		else $error("scl not held while job done");
	chk_off_release: assert property
		(reg_wr && reg_addr == `TWS_OFF_CTRL && !reg_wdata[`TWS_CTL_EN]
		|-> ##[1:4] (!scl_oe && !sda_oe))
		else $error("pins held after disable");
	chk_od_low: assert property
		(!scl_out && !sda_out)
		else $error("open drain output driven high");
endmodule // tws_ctrl_assertions
bind tws_ctrl tws_ctrl_assertions u_chk (.sys_clk, .rst, .reg_addr,
	.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .global_irq_enable, .irq,
	.scl_out, .scl_oe, .sda_out, .sda_oe);

// file: verif/tws_bus_peer.sv
// Behavioural far-side master on the two-wire bus
`timescale 1ns/10ps
module tws_bus_peer
(
	// Clock
	input  wire logic       sys_clk,
	// Bench request and result
	input  wire logic       go,
	input  wire logic [7:0] tx_byte,
	output logic            busy,
	output logic            acked,
	// Resolved wire levels and pulls
	input  wire logic       scl,
	input  wire logic       sda,
	output logic            scl_pull,
	output logic            sda_pull
);
	int i;
	int k;
	task automatic half();
		repeat (20) @(posedge sys_clk);
	endtask
	// Release SCL and wait out a stretching slave, bounded
	task automatic rise();
		scl_pull <= 1'b0;
		for (k = 0; k < 4000 && !scl; k++)
			@(posedge sys_clk);
		half();
	endtask
	initial
	begin
		{busy, acked, scl_pull, sda_pull} = 4'h0;
		forever
		begin
			@(posedge sys_clk);
			if (go)
			begin
				busy <= 1'b1;
				sda_pull <= 1'b1;
				half();
				scl_pull <= 1'b1;
				// SDA moves mid-low so the filters never see a false STOP
				for (i = 0; i < 9; i++)
				begin
					half();
					sda_pull <= i < 8 ? ~tx_byte[3'(7 - i)] : 1'b0;
					half();
					rise();
					if (i == 8)
						acked <= !sda;
					scl_pull <= 1'b1;
				end
				half();
				sda_pull <= 1'b1;
				half();
				rise();
				sda_pull <= 1'b0;
				half();
				busy <= 1'b0;
			end
		end
	end
endmodule // tws_bus_peer

// file: verif/tws_ctrl_bench.sv
// Self-checking bench for the two-wire controller
`include "tws_map.svh"
`timescale 1ns/10ps
module tws_ctrl_bench;
	logic       sys_clk, rst, reg_wr, reg_rd, gie, go, busy, acked;
	logic       irq, scl_oe, sda_oe, scl_out, sda_out, scl_pull, sda_pull;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, tx, v;
	logic [6:0] a7, m7, f7;
	logic       gce, acken, exp_ack;
	wire        scl = ~(scl_oe | scl_pull);
	wire        sda = ~(sda_oe | sda_pull);
	int         n_fail, n_tests, c, k;
	tws_ctrl uut
	(
		.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .global_irq_enable(gie), .irq(irq),
		.scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe),
		.sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe)
	);
	tws_bus_peer peer
	(
		.sys_clk(sys_clk), .go(go), .tx_byte(tx), .busy(busy),
		.acked(acked), .scl(scl), .sda(sda), .scl_pull(scl_pull),
		.sda_pull(sda_pull)
	);
	function automatic logic [7:0] rv(input int i);
		case (i)
			1: return 8'hf8;
			2: return 8'hfe;
			3: return 8'hff;
			default: return 8'h00;
		endcase
	endfunction
	task automatic chk(input string n, input logic [7:0] e, g);
		n_tests++;
		if (g !== e)
		begin
			n_fail++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(negedge sys_clk);
		d = reg_rdata;
		@(posedge sys_clk);
	endtask
	task automatic rc(input string n, input logic [7:0] a, e);
		logic [7:0] g;
		rd(a, g);
		chk(n, e, g);
	endtask
	task automatic wait_done();
		int j;
		v = 8'h00;
		for (j = 0; j < 300 && !v[7]; j++)
			rd(`TWS_OFF_CTRL, v);
		chk("done", 8'h80, v & 8'h80);
	endtask
	task automatic final_report();
		if (n_fail == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial
	begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	initial
	begin
		#4000000;
		n_fail++;
		final_report();
	end
	initial
	begin
		rst = 1'b1;
		{reg_wr, reg_rd, gie, go} = 4'h0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		tx = 8'h00;
		n_fail = 0;
		n_tests = 0;
		k = $urandom(23);
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		for (c = 0; c < 7; c++)
			rc("reset", 8'hb8 + 8'(c), rv(c));
		v = 8'($urandom);
		wr(`TWS_OFF_STATUS, v);
		rc("status", `TWS_OFF_STATUS, {6'h3e, v[1:0]});
		wr(`TWS_OFF_RATE, v);
		rc("rate", `TWS_OFF_RATE, v);
		wr(`TWS_OFF_RATE, 8'h00);
		wr(`TWS_OFF_STATUS, 8'h00);
		wr(`TWS_OFF_CTRL, 8'h4d);
		rc("ctrl", `TWS_OFF_CTRL, 8'h45);
		wr(`TWS_OFF_DATA, 8'h3c);
		rc("data", `TWS_OFF_DATA, 8'hff);
		rc("ctrl", `TWS_OFF_CTRL, 8'h4d);
		wr(`TWS_OFF_CTRL, 8'ha4);
		wait_done();
		rc("status", `TWS_OFF_STATUS, 8'h08);
		rc("ctrl", `TWS_OFF_CTRL, 8'hac);
		wr(`TWS_OFF_DATA, 8'h5a);
		rc("data", `TWS_OFF_DATA, 8'h5a);
		rc("ctrl", `TWS_OFF_CTRL, 8'ha4);
		wr(`TWS_OFF_CTRL, 8'h84);
		wait_done();
		rc("status", `TWS_OFF_STATUS, 8'h20);
		rc("data", `TWS_OFF_DATA, 8'h5a);
		wr(`TWS_OFF_CTRL, 8'h94);
		repeat (100) @(posedge sys_clk);
		rc("ctrl", `TWS_OFF_CTRL, 8'h04);
		chk("wires", 8'h03, {6'h0, scl, sda});
		for (c = 0; c < 7; c++)
		begin
			a7 = 7'($urandom) | 7'h20;
			m7 = 7'($urandom) & 7'h1f;
			f7 = 7'($urandom) & m7;
			if (c % 3 == 1)
				f7 = f7 | 7'h40;
			tx = (c % 3 == 2) ? 8'h00 : {a7 ^ f7, 1'b0};
			gce = (c == 2) || ((c != 5) && $urandom % 2 == 1);
			acken = (c != 3);
			exp_ack = acken && (c % 3 == 0 || (c % 3 == 2 && gce));
			gie <= 1'($urandom);
			wr(`TWS_OFF_OWN, {a7, gce});
			wr(`TWS_OFF_MASK, {m7, 1'b1});
			rc("mask", `TWS_OFF_MASK, {m7, 1'b0});
			wr(`TWS_OFF_CTRL, {1'b1, acken, 6'h05});
			go <= 1'b1;
			@(posedge sys_clk);
			go <= 1'b0;
			@(posedge sys_clk);
			if (exp_ack)
			begin
				wait_done();
				rc("status", `TWS_OFF_STATUS, c % 3 == 2 ? 8'h70 : 8'h60);
				chk("irq", {7'h0, gie}, {7'h0, irq});
				repeat (60) @(posedge sys_clk);
				chk("scl", 8'h00, {7'h0, scl});
				wr(`TWS_OFF_CTRL, 8'hd5);
			end
			for (k = 0; k < 3000 && busy; k++)
				@(posedge sys_clk);
			chk("ack", {7'h0, exp_ack}, {7'h0, acked});
			rc("data", `TWS_OFF_DATA, tx);
			rc("ctrl", `TWS_OFF_CTRL, {1'b0, acken, 6'h05});
		end
		wr(`TWS_OFF_CTRL, 8'h00);
		repeat (4) @(posedge sys_clk);
		chk("off", 8'h03, {6'h0, scl, sda});
		final_report();
	end
endmodule // tws_ctrl_bench
